// ==== common/pllc_params.svh ====
`ifndef PLLC_PARAMS_SVH
`define PLLC_PARAMS_SVH

// register offsets (byte addresses)
`define PLLC_ADDR_W          8
`define PLLC_OFS_PLLCTRL     8'h00
`define PLLC_OFS_CLKSEL      8'h04
`define PLLC_OFS_OSCCFG      8'h08
`define PLLC_OFS_STATUS      8'h0C
`define PLLC_OFS_FREQ        8'h10

// pll control fields
`define PLLC_DIV_LSB         0
`define PLLC_SRC_BIT         4
`define PLLC_MUL_LSB         8

// clock select fields
`define PLLC_CKSEL_LSB       0
`define PLLC_UCK_LSB         4
`define PLLC_USBEN_BIT       7

// oscillator config fields
`define PLLC_FRQ_LSB         0
`define PLLC_FLL_BIT         2
`define PLLC_OSD_BIT         3

// status fields
`define PLLC_ST_LOWFREQ      0
`define PLLC_ST_MULERR       1
`define PLLC_ST_VIACAC       2
`define PLLC_ST_VIAPLL       3
`define PLLC_ST_USBSRCERR    4
`define PLLC_ST_USBOK        5
`define PLLC_ST_RATIO_LSB    8

// reset values
`define PLLC_RST_DIV         2'h0
`define PLLC_RST_SRC         1'h0
`define PLLC_RST_MUL         6'h13
`define PLLC_RST_CKSEL       3'h0
`define PLLC_RST_UCK         3'h4
`define PLLC_RST_FRQ         2'h0

// multiplier codes and ratios (ratio held in half units)
`define PLLC_MUL_X10         6'h13
`define PLLC_MUL_X20         6'h26
`define PLLC_MUL_X14P5       6'h1C
`define PLLC_MUL_X13         6'h19
`define PLLC_MUL_X11P5       6'h16
`define PLLC_RATIO_X20       8'h28
`define PLLC_RATIO_MIN_OSD   8'h14
`define PLLC_RATIO_MAX_OSD   8'h28

// frequencies in kHz, and the system clock select code for the pll
`define PLLC_LOWFREQ_KHZ     32'd12000
`define PLLC_USB_KHZ         32'd48000
`define PLLC_FAST_16_KHZ     32'd16000
`define PLLC_FAST_18_KHZ     32'd18000
`define PLLC_FAST_20_KHZ     32'd20000
`define PLLC_CKSEL_PLL       3'h5

`endif

// ==== common/pllc_pkg.sv ====
package pllc_pkg;

    typedef enum logic {
        PLLC_SRC_MAIN,
        PLLC_SRC_FAST
    } pllc_src_e;

    typedef enum logic [1:0] {
        PLLC_FRQ_16,
        PLLC_FRQ_18,
        PLLC_FRQ_20,
        PLLC_FRQ_RSVD
    } pllc_frq_e;

    typedef logic [7:0] pllc_ratio_t;

    // multiplier code to ratio in half units
    function automatic pllc_ratio_t pllc_ratio_half(input logic [5:0] code);
        if (code == 6'h26)
            return 8'h28;
        return {2'h0, code} + 8'h01;
    endfunction

endpackage

// ==== core/pllc_freq_calc.sv ====
`timescale 1ns/100ps
`include "pllc_params.svh"

module pllc_freq_calc
    import pllc_pkg::*;
#(
    parameter logic [31:0] MAIN_OSC_KHZ = 32'd12000
) (
    input  wire logic        srcSel,
    input  wire logic [1:0]  freqSel,
    input  wire logic [1:0]  inDiv,
    input  wire logic [5:0]  mult,
    output logic      [31:0] refKhz,
    output pllc_ratio_t      ratioHalf,
    output logic      [31:0] outKhz
);

    logic [31:0] fastKhz;
    logic [31:0] divKhz;
    logic [47:0] prod;

    // fast oscillator frequency per selection, reserved code reads as 16 MHz
    assign fastKhz = (pllc_frq_e'(freqSel) == PLLC_FRQ_18) ? `PLLC_FAST_18_KHZ :
                     (pllc_frq_e'(freqSel) == PLLC_FRQ_20) ? `PLLC_FAST_20_KHZ :
                                                             `PLLC_FAST_16_KHZ;
    assign refKhz    = (pllc_src_e'(srcSel) == PLLC_SRC_FAST) ? fastKhz : MAIN_OSC_KHZ;
    assign divKhz    = (inDiv == 2'h1) ? refKhz / 32'd2 :
                       (inDiv == 2'h2) ? refKhz / 32'd3 : refKhz;
    assign ratioHalf = pllc_ratio_half(mult);
    assign prod      = {16'h0000, divKhz} * {40'h0, ratioHalf};
    assign outKhz    = prod[32:1];

endmodule

// ==== core/pllc_clock_config.sv ====
`timescale 1ns/100ps
`include "pllc_params.svh"

module pllc_clock_config
    import pllc_pkg::*;
#(
    parameter logic [31:0] MAIN_OSC_KHZ = 32'd12000
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [`PLLC_ADDR_W-1:0] addr,
    input  wire logic [31:0]             wrData,
    input  wire logic                    wrStb,
    input  wire logic                    rdStb,
    output logic      [31:0]             rdData,
    output logic      [5:0]              pllMultiplier,
    output logic                         pllSourceSelect,
    output logic      [1:0]              pllInputDivider,
    output logic      [2:0]              systemClockSourceSelect,
    output logic      [2:0]              usbClockDivider,
    output logic      [1:0]              internalOscFreqSelect,
    output logic                         frequencyLockedLoopEn,
    output logic                         oscStopDetectEn,
    output logic                         oscStopViaChecker,
    output logic                         oscStopViaPll,
    output logic                         mulRangeErr,
    output logic                         usbSrcErr,
    output logic                         usbClockOk,
    output logic      [31:0]             pllOutKhz
);

    // configuration registers
    logic [5:0]  mul_q;
    logic        src_q;
    logic [1:0]  div_q;
    logic [2:0]  cksel_q;
    logic [2:0]  uck_q;
    logic        usbEn_q;
    logic [1:0]  frq_q;
    logic        fll_q;
    logic        osd_q;

    // derived state registers
    logic        viaCac_q;
    logic        viaPll_q;
    logic        mulErr_q;
    logic        usbSrcErr_q;
    logic        usbOk_q;
    logic        lowFreq_q;
    logic [7:0]  ratio_q;
    logic [31:0] outKhz_q;
    logic [31:0] rdData_q;

    // decode and next values
    logic        selPll;
    logic        selClk;
    logic        selOsc;
    logic        selStat;
    logic        selFreq;
    logic [31:0] refKhz;
    pllc_ratio_t ratioHalf;
    logic [31:0] outKhz;
    logic [31:0] usbKhz;
    logic        lowFreq_d;
    logic        mulErr_d;
    logic        viaCac_d;
    logic        viaPll_d;
    logic        usbSrcErr_d;
    logic        usbOk_d;
    logic [31:0] statWord;
    logic [31:0] pllWord;
    logic [31:0] clkWord;
    logic [31:0] oscWord;
    logic [31:0] rdData_d;

    pllc_freq_calc #(
        .MAIN_OSC_KHZ (MAIN_OSC_KHZ)
    ) u_calc (
        .srcSel    (src_q),
        .freqSel   (frq_q),
        .inDiv     (div_q),
        .mult      (mul_q),
        .refKhz    (refKhz),
        .ratioHalf (ratioHalf),
        .outKhz    (outKhz)
    );

    assign selPll  = (addr == `PLLC_OFS_PLLCTRL);
    assign selClk  = (addr == `PLLC_OFS_CLKSEL);
    assign selOsc  = (addr == `PLLC_OFS_OSCCFG);
    assign selStat = (addr == `PLLC_OFS_STATUS);
    assign selFreq = (addr == `PLLC_OFS_FREQ);

    // oscillation stop routing and multiplier range check
    assign lowFreq_d = (refKhz < `PLLC_LOWFREQ_KHZ);
    assign mulErr_d  = osd_q && lowFreq_d &&
                       ((ratioHalf < `PLLC_RATIO_MIN_OSD) ||
                        (ratioHalf > `PLLC_RATIO_MAX_OSD));
    assign viaPll_d  = osd_q && lowFreq_d;
    assign viaCac_d  = osd_q && !lowFreq_d;

    // usb clock source checks
    assign usbKhz      = outKhz / ({29'h0, uck_q} + 32'd1);
    assign usbSrcErr_d = usbEn_q && src_q;
    assign usbOk_d     = usbEn_q && !src_q && (cksel_q == `PLLC_CKSEL_PLL) &&
                         (usbKhz == `PLLC_USB_KHZ);

    assign pllWord = ({26'h0, mul_q} << `PLLC_MUL_LSB) |
                     ({31'h0, src_q} << `PLLC_SRC_BIT) |
                     ({30'h0, div_q} << `PLLC_DIV_LSB);
    assign clkWord = ({29'h0, cksel_q} << `PLLC_CKSEL_LSB) |
                     ({29'h0, uck_q} << `PLLC_UCK_LSB) |
                     ({31'h0, usbEn_q} << `PLLC_USBEN_BIT);
    assign oscWord = ({30'h0, frq_q} << `PLLC_FRQ_LSB) |
                     ({31'h0, fll_q} << `PLLC_FLL_BIT) |
                     ({31'h0, osd_q} << `PLLC_OSD_BIT);
    assign statWord = ({31'h0, lowFreq_q} << `PLLC_ST_LOWFREQ) |
                      ({31'h0, mulErr_q} << `PLLC_ST_MULERR) |
                      ({31'h0, viaCac_q} << `PLLC_ST_VIACAC) |
                      ({31'h0, viaPll_q} << `PLLC_ST_VIAPLL) |
                      ({31'h0, usbSrcErr_q} << `PLLC_ST_USBSRCERR) |
                      ({31'h0, usbOk_q} << `PLLC_ST_USBOK) |
                      ({24'h0, ratio_q} << `PLLC_ST_RATIO_LSB);

    // read mux, unmapped addresses and idle cycles read zero
    assign rdData_d = !rdStb ? 32'h0 :
                      selPll  ? pllWord :
                      selClk  ? clkWord :
                      selOsc  ? oscWord :
                      selStat ? statWord :
                      selFreq ? outKhz_q : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mul_q <= `PLLC_RST_MUL;
            src_q <= `PLLC_RST_SRC;
            div_q <= `PLLC_RST_DIV;
        end else if (wrStb && selPll) begin
            mul_q <= wrData[`PLLC_MUL_LSB +: 6];
            src_q <= wrData[`PLLC_SRC_BIT];
            div_q <= wrData[`PLLC_DIV_LSB +: 2];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cksel_q <= `PLLC_RST_CKSEL;
            uck_q   <= `PLLC_RST_UCK;
            usbEn_q <= 1'h0;
        end else if (wrStb && selClk) begin
            cksel_q <= wrData[`PLLC_CKSEL_LSB +: 3];
            uck_q   <= wrData[`PLLC_UCK_LSB +: 3];
            usbEn_q <= wrData[`PLLC_USBEN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frq_q <= `PLLC_RST_FRQ;
            fll_q <= 1'h0;
            osd_q <= 1'h0;
        end else if (wrStb && selOsc) begin
            frq_q <= wrData[`PLLC_FRQ_LSB +: 2];
            fll_q <= wrData[`PLLC_FLL_BIT];
            osd_q <= wrData[`PLLC_OSD_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowFreq_q   <= 1'h0;
            mulErr_q    <= 1'h0;
            viaCac_q    <= 1'h0;
            viaPll_q    <= 1'h0;
            usbSrcErr_q <= 1'h0;
            usbOk_q     <= 1'h0;
            ratio_q     <= 8'h00;
            outKhz_q    <= 32'h0;
            rdData_q    <= 32'h0;
        end else begin
            lowFreq_q   <= lowFreq_d;
            mulErr_q    <= mulErr_d;
            viaCac_q    <= viaCac_d;
            viaPll_q    <= viaPll_d;
            usbSrcErr_q <= usbSrcErr_d;
            usbOk_q     <= usbOk_d;
            ratio_q     <= ratioHalf;
            outKhz_q    <= outKhz;
            rdData_q    <= rdData_d;
        end
    end

    assign rdData                  = rdData_q;
    assign pllMultiplier           = mul_q;
    assign pllSourceSelect         = src_q;
    assign pllInputDivider         = div_q;
    assign systemClockSourceSelect = cksel_q;
    assign usbClockDivider         = uck_q;
    assign internalOscFreqSelect   = frq_q;
    assign frequencyLockedLoopEn   = fll_q;
    assign oscStopDetectEn         = osd_q;
    assign oscStopViaChecker       = viaCac_q;
    assign oscStopViaPll           = viaPll_q;
    assign mulRangeErr             = mulErr_q;
    assign usbSrcErr               = usbSrcErr_q;
    assign usbClockOk              = usbOk_q;
    assign pllOutKhz               = outKhz_q;

endmodule

// ==== sim/pllc_chk.sv ====
`timescale 1ns/100ps
module pllc_chk
    import pllc_pkg::*;
#(
    parameter logic [31:0] MAIN_OSC_KHZ = 32'd12000
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [31:0] rdData,
    input wire logic [5:0]  pllMultiplier,
    input wire logic        pllSourceSelect,
    input wire logic [1:0]  pllInputDivider,
    input wire logic [2:0]  systemClockSourceSelect,
    input wire logic        oscStopDetectEn,
    input wire logic        oscStopViaChecker,
    input wire logic        oscStopViaPll,
    input wire logic        mulRangeErr,
    input wire logic        usbSrcErr,
    input wire logic        usbClockOk,
    input wire logic [31:0] pllOutKhz
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic pllWr = wrStb && addr == 8'h00;

    chk_rd_idle: assert property (!$past(rdStb) |-> rdData == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_src_write: assert property (pllWr |=> pllSourceSelect == $past(wrData[4]))
        else $error("source select did not take written bit");
    chk_mul_write: assert property (pllWr |=> pllMultiplier == $past(wrData[13:8]))
        else $error("multiplier did not take written field");
    chk_cfg_hold: assert property (
        !pllWr |=> $stable(pllMultiplier) && $stable(pllSourceSelect))
        else $error("pll config changed without a write");
    chk_route_excl: assert property (!(oscStopViaChecker && oscStopViaPll))
        else $error("stop detect routed two ways");
    chk_err_via_pll: assert property (mulRangeErr |-> oscStopViaPll)
        else $error("range error outside pll route");
    chk_stop_off: assert property (
        !$past(rst) && !$past(oscStopDetectEn) |-> !oscStopViaChecker && !oscStopViaPll)
        else $error("stop route active while detect off");
    chk_stop_on: assert property (
        !$past(rst) && $past(oscStopDetectEn) |-> oscStopViaChecker || oscStopViaPll)
        else $error("stop route missing while detect on");
    chk_usb_src: assert property (!$past(rst) && usbSrcErr |-> $past(pllSourceSelect))
        else $error("usb source error without fast source");
    chk_usb_ok: assert property (!$past(rst) && usbClockOk |->
        !$past(pllSourceSelect) && $past(systemClockSourceSelect) == 3'h5)
        else $error("usb ok with wrong clock source");
    chk_x20_out: assert property (!$past(rst) && $past(pllMultiplier) == 6'h26
        && $past(pllInputDivider) == 2'h0 && !$past(pllSourceSelect)
        |-> pllOutKhz == MAIN_OSC_KHZ * 20)
        else $error("x20 code gave wrong pll output");

    cover property (pllWr && wrData[13:8] == 6'h26);
    cover property (usbClockOk);
    cover property (oscStopViaChecker);
    cover property (mulRangeErr);
endmodule

bind pllc_clock_config pllc_chk #(.MAIN_OSC_KHZ(MAIN_OSC_KHZ)) chkI (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .pllMultiplier(pllMultiplier), .pllSourceSelect(pllSourceSelect),
    .pllInputDivider(pllInputDivider), .systemClockSourceSelect(systemClockSourceSelect),
    .oscStopDetectEn(oscStopDetectEn), .oscStopViaChecker(oscStopViaChecker),
    .oscStopViaPll(oscStopViaPll), .mulRangeErr(mulRangeErr), .usbSrcErr(usbSrcErr),
    .usbClockOk(usbClockOk), .pllOutKhz(pllOutKhz)
);

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
    import pllc_pkg::*;
;
    typedef struct {logic [1:0] frq; logic [31:0] ctrl; logic [31:0] khz;} pllc_row_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic        wrStb = 1'b0;
    logic        rdStb = 1'b0;
    logic [31:0] rdData;
    logic [31:0] pllOutKhz;
    logic [5:0]  pllMultiplier;
    logic        pllSourceSelect;
    logic        viaChk;
    logic        viaPll;
    logic        usbErr;
    logic        usbOk;
    logic [1:0]  inDiv;
    logic [2:0]  ckSel;
    logic [2:0]  usbDiv;
    logic [1:0]  frqSel;
    logic        fllEn;
    logic        osdEn;
    logic        mulErr;
    logic        lowViaPll;
    logic        lowMulErr;
    int          badCount = 0;
    int          samplesChecked = 0;
    pllc_row_s   rows [7] = '{'{2'h0, 32'h1300, 32'h1D4C0}, '{2'h0, 32'h2600, 32'h3A980},
        '{2'h0, 32'h1C10, 32'h38A40}, '{2'h1, 32'h1910, 32'h39210},
        '{2'h2, 32'h1610, 32'h38270}, '{2'h0, 32'h2602, 32'h13880},
        '{2'h0, 32'h1303, 32'h1D4C0}};

    pllc_clock_config #(.MAIN_OSC_KHZ(32'd12000)) uut (
        .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(rdData), .pllMultiplier(pllMultiplier), .pllSourceSelect(pllSourceSelect),
        .pllInputDivider(inDiv), .systemClockSourceSelect(ckSel), .usbClockDivider(usbDiv),
        .internalOscFreqSelect(frqSel), .frequencyLockedLoopEn(fllEn), .oscStopDetectEn(osdEn),
        .oscStopViaChecker(viaChk), .oscStopViaPll(viaPll), .mulRangeErr(mulErr),
        .usbSrcErr(usbErr), .usbClockOk(usbOk), .pllOutKhz(pllOutKhz)
    );

    // second copy with a slow main crystal, so the low input route is reached
    pllc_clock_config #(.MAIN_OSC_KHZ(32'd8000)) uutLow (
        .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(), .pllMultiplier(), .pllSourceSelect(), .pllInputDivider(),
        .systemClockSourceSelect(), .usbClockDivider(), .internalOscFreqSelect(),
        .frequencyLockedLoopEn(), .oscStopDetectEn(), .oscStopViaChecker(),
        .oscStopViaPll(lowViaPll), .mulRangeErr(lowMulErr), .usbSrcErr(), .usbClockOk(),
        .pllOutKhz()
    );

    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic endOfTest;
        $display("checks %0d, mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #500000;
        badCount++;
        endOfTest();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h1300);
        rd(8'h04, 32'h40);
        rd(8'h08, 32'h0);
        chk(pllOutKhz, 32'h1D4C0);
        $display("reset values done");
        foreach (rows[i]) begin
            wr(8'h08, {30'h0, rows[i].frq});
            wr(8'h00, rows[i].ctrl);
            settle();
            chk(pllOutKhz, rows[i].khz);
            chk({26'h0, pllMultiplier}, {26'h0, rows[i].ctrl[13:8]});
            chk({31'h0, pllSourceSelect}, {31'h0, rows[i].ctrl[4]});
            chk({28'h0, inDiv, frqSel}, {28'h0, rows[i].ctrl[1:0], rows[i].frq});
            rd(8'h00, rows[i].ctrl);
            rd(8'h10, rows[i].khz);
        end
        $display("multiplier table done");
        wr(8'h08, 32'h8);
        wr(8'h00, 32'h1300);
        settle();
        chk({30'h0, viaPll, viaChk}, 32'h1);
        chk({29'h0, lowViaPll, lowMulErr, mulErr}, 32'h4);
        wr(8'h00, 32'h2600);
        settle();
        chk({29'h0, lowViaPll, lowMulErr, mulErr}, 32'h4);
        wr(8'h00, 32'h2800);
        settle();
        chk({29'h0, lowViaPll, lowMulErr, mulErr}, 32'h6);
        wr(8'h00, 32'h1200);
        settle();
        chk({29'h0, lowViaPll, lowMulErr, mulErr}, 32'h6);
        wr(8'h08, 32'hA);
        wr(8'h00, 32'h1610);
        settle();
        chk({30'h0, viaPll, viaChk}, 32'h1);
        chk({29'h0, lowViaPll, lowMulErr, mulErr}, 32'h0);
        wr(8'h08, 32'h0);
        settle();
        chk({30'h0, viaPll, viaChk}, 32'h0);
        $display("stop detect routing done");
        wr(8'h04, 32'hC5);
        wr(8'h00, 32'h2600);
        settle();
        chk({30'h0, usbErr, usbOk}, 32'h1);
        chk({26'h0, ckSel, usbDiv}, 32'h2C);
        rd(8'h0C, 32'h2820);
        wr(8'h00, 32'h2610);
        settle();
        chk({30'h0, usbErr, usbOk}, 32'h2);
        $display("usb source done");
        wr(8'h0C, 32'hFFFFFFFF);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h3F00);
        rd(8'h14, 32'h0);
        rd(8'h00, 32'h2610);
        rd(8'h10, 32'h4E200);
        wr(8'h08, 32'hC);
        settle();
        chk({30'h0, fllEn, osdEn}, 32'h3);
        rd(8'h08, 32'hC);
        $display("refused writes done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk({25'h0, pllSourceSelect, pllMultiplier}, 32'h13);
        chk(pllOutKhz, 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(pllOutKhz, 32'h1D4C0);
        rd(8'h0C, 32'h1400);
        $display("mid run reset done");
        endOfTest();
    end
endmodule
